// ==== rtl/cond_flow_pkg.sv ====
`default_nettype none

package cond_flow_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DATA_W   = 8;
  localparam int PC_W_DEF = 12;
  localparam int OFF_W    = 7;
  localparam int SEL_W    = 3;

  // ****************************************************************
  // Status register bit positions
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ****************************************************************
  // Cycle counts and program counter steps
  // ****************************************************************
  localparam logic [1:0] CYC_PLAIN     = 2'h1;
  localparam logic [1:0] CYC_BR_TAKEN  = 2'h2;
  localparam logic [1:0] CYC_SKIP_ONE  = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO  = 2'h3;
  localparam logic [1:0] STEP_SEQ      = 2'h1;
  localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
  localparam logic [1:0] STEP_SKIP_TWO = 2'h3;

  // ****************************************************************
  // Operations and states
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NONE                  = 4'h0,
    OP_COMPARE_IMMEDIATE     = 4'h1,
    OP_SKIP_REG_BIT_CLEAR    = 4'h2,
    OP_SKIP_REG_BIT_SET      = 4'h3,
    OP_SKIP_IO_BIT_CLEAR     = 4'h4,
    OP_SKIP_IO_BIT_SET       = 4'h5,
    OP_BRANCH_FLAG_SET       = 4'h6,
    OP_BRANCH_FLAG_CLEAR     = 4'h7,
    OP_BRANCH_EQUAL          = 4'h8,
    OP_BRANCH_NOT_EQUAL      = 4'h9,
    OP_BRANCH_CARRY_SET      = 4'hA,
    OP_BRANCH_LOWER          = 4'hB,
    OP_BRANCH_CARRY_CLEAR    = 4'hC,
    OP_BRANCH_SAME_OR_HIGHER = 4'hD,
    OP_BRANCH_MINUS          = 4'hE,
    OP_BRANCH_PLUS           = 4'hF
  } op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } state_e;

  typedef struct packed {
    op_e              op;
    logic [DATA_W-1:0] reg_val;
    logic [DATA_W-1:0] imm;
    logic [DATA_W-1:0] io_val;
    logic [SEL_W-1:0]  bit_sel;
    logic [OFF_W-1:0]  offset;
    logic              next_two_word;
  } instr_s;

endpackage : cond_flow_pkg

`default_nettype wire

// ==== rtl/bit_pick.sv ====
`default_nettype none

module bit_pick #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]         value,  // Byte under test
  input  wire logic [$clog2(W)-1:0] sel,    // Bit number
  output logic                      bit_o   // Selected bit
);

  assign bit_o = value[sel];

endmodule : bit_pick

`default_nettype wire

// ==== rtl/cmp_flags.sv ====
`default_nettype none

module cmp_flags
  import cond_flow_pkg::*;
(
  input  wire logic [DATA_W-1:0] a,  // Minuend
  input  wire logic [DATA_W-1:0] b,  // Subtrahend
  output logic                   z,  // Zero
  output logic                   n,  // Negative
  output logic                   v,  // Two's complement overflow
  output logic                   c,  // Borrow out of bit 7
  output logic                   h   // Borrow out of bit 3
);

  logic [DATA_W-1:0] r;

  // ****************************************************************
  // Subtract without keeping the result
  // ****************************************************************
  assign r = a - b;
  assign z = (r == 8'h00);
  assign n = r[7];
  assign v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  assign c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
  assign h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);

endmodule : cmp_flags

`default_nettype wire

// ==== rtl/compare_skip_branch_unit.sv ====
`default_nettype none

// How it works
// - Compare-immediate subtracts, sets ZNVCH, one cycle
// - Skip when register bit clear, flags kept
// - Skip when register bit set, flags kept
// - Skip when I/O bit clear, flags kept
// - Skip when I/O bit set, flags kept
// - Branch when selected status bit is one
// - Branch when selected status bit is zero
// - Branch when zero flag set
// - Branch when zero flag clear
// - Carry-set and lower branch on carry one
// - Branch when carry flag clear
// - Same-or-higher equals carry-clear branch
// - Branch when negative flag set
// - Branch when negative flag clear
module compare_skip_branch_unit
  import cond_flow_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
) (
  input  wire logic            clk,          // Core clock
  input  wire logic            resetn,       // Asynchronous reset, active low
  input  wire logic            issue_valid,  // Instruction offered
  input  wire instr_s          issue,        // Decoded instruction and operands
  input  wire logic [PC_W-1:0] pc_in,        // Address of the offered instruction
  input  wire logic [7:0]      status_in,    // Current status register
  output logic                 issue_ready,  // Instruction can be taken this cycle
  output logic                 done,         // Last cycle of the instruction
  output logic                 busy,         // Instruction in progress
  output logic [PC_W-1:0]      pc_next,      // Next program counter
  output logic                 pc_load,      // Load pc_next into the program counter
  output logic [7:0]           status_out,   // New status register
  output logic                 status_we,    // Write status_out
  output logic                 taken         // Skip or branch was taken
);

  // ****************************************************************
  // Operand tests
  // ****************************************************************
  logic reg_bit;
  logic io_bit;
  logic stat_bit;
  logic cz, cn, cv, cc, ch;

  bit_pick #(.W(DATA_W)) u_reg_bit (
    .value (issue.reg_val),
    .sel   (issue.bit_sel),
    .bit_o (reg_bit)
  );

  bit_pick #(.W(DATA_W)) u_io_bit (
    .value (issue.io_val),
    .sel   (issue.bit_sel),
    .bit_o (io_bit)
  );

  bit_pick #(.W(DATA_W)) u_stat_bit (
    .value (status_in),
    .sel   (issue.bit_sel),
    .bit_o (stat_bit)
  );

  cmp_flags u_cmp (
    .a (issue.reg_val),
    .b (issue.imm),
    .z (cz),
    .n (cn),
    .v (cv),
    .c (cc),
    .h (ch)
  );

  // ****************************************************************
  // Decision
  // ****************************************************************
  logic            skip_take;
  logic            br_take;
  logic            is_cmp;
  logic [PC_W-1:0] off_ext;

  assign off_ext = {{(PC_W-OFF_W){issue.offset[OFF_W-1]}}, issue.offset};

  always_comb begin
    skip_take = 1'b0;
    br_take   = 1'b0;
    is_cmp    = 1'b0;
    case (issue.op)
      OP_COMPARE_IMMEDIATE:     is_cmp    = 1'b1;
      OP_SKIP_REG_BIT_CLEAR:    skip_take = ~reg_bit;
      OP_SKIP_REG_BIT_SET:      skip_take = reg_bit;
      OP_SKIP_IO_BIT_CLEAR:     skip_take = ~io_bit;
      OP_SKIP_IO_BIT_SET:       skip_take = io_bit;
      OP_BRANCH_FLAG_SET:       br_take   = stat_bit;
      OP_BRANCH_FLAG_CLEAR:     br_take   = ~stat_bit;
      OP_BRANCH_EQUAL:          br_take   = status_in[FLAG_Z];
      OP_BRANCH_NOT_EQUAL:      br_take   = ~status_in[FLAG_Z];
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:          br_take   = status_in[FLAG_C];
      OP_BRANCH_CARRY_CLEAR:    br_take   = ~status_in[FLAG_C];
      OP_BRANCH_SAME_OR_HIGHER: br_take   = ~status_in[FLAG_C];
      OP_BRANCH_MINUS:          br_take   = status_in[FLAG_N];
      OP_BRANCH_PLUS:           br_take   = ~status_in[FLAG_N];
      default: begin
        skip_take = 1'b0;
        br_take   = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  state_e          state_q, state_d;
  logic [1:0]      remain_q, remain_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0]      status_q, status_d;
  logic            we_q, we_d;
  logic            taken_q, taken_d;
  logic            accept;

  assign done        = (state_q == ST_WAIT) && (remain_q == 2'h0);
  assign issue_ready = (state_q == ST_IDLE) || done;
  assign accept      = issue_valid && issue_ready;
  assign busy        = (state_q == ST_WAIT);

  always_comb begin
    state_d  = state_q;
    remain_d = remain_q;
    pc_d     = pc_q;
    status_d = status_q;
    we_d     = we_q;
    taken_d  = taken_q;
    if (accept) begin
      state_d  = ST_WAIT;
      status_d = status_in;
      we_d     = 1'b0;
      taken_d  = skip_take || br_take;
      pc_d     = pc_in + PC_W'(STEP_SEQ);
      remain_d = CYC_PLAIN - 2'h1;
      if (is_cmp) begin
        status_d[FLAG_Z] = cz;
        status_d[FLAG_N] = cn;
        status_d[FLAG_V] = cv;
        status_d[FLAG_C] = cc;
        status_d[FLAG_H] = ch;
        we_d             = 1'b1;
      end
      if (skip_take) begin
        if (issue.next_two_word) begin
          pc_d     = pc_in + PC_W'(STEP_SKIP_TWO);
          remain_d = CYC_SKIP_TWO - 2'h1;
        end else begin
          pc_d     = pc_in + PC_W'(STEP_SKIP_ONE);
          remain_d = CYC_SKIP_ONE - 2'h1;
        end
      end
      if (br_take) begin
        pc_d     = pc_in + off_ext + PC_W'(STEP_SEQ);
        remain_d = CYC_BR_TAKEN - 2'h1;
      end
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_WAIT: begin
          if (done) begin
            state_d = ST_IDLE;
          end else begin
            remain_d = remain_q - 2'h1;
          end
        end
        // Stray state codes fall back to idle
        default: begin
          state_d  = ST_IDLE;
          remain_d = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= ST_IDLE;
      remain_q <= 2'h0;
      pc_q     <= '0;
      status_q <= STATUS_RST;
      we_q     <= 1'b0;
      taken_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      remain_q <= remain_d;
      pc_q     <= pc_d;
      status_q <= status_d;
      we_q     <= we_d;
      taken_q  <= taken_d;
    end
  end

  // Flags only change through compare; every other op leaves status_we low
  assign pc_next    = pc_q;
  assign pc_load    = done;
  assign status_out = status_q;
  assign status_we  = done && we_q;
  assign taken      = taken_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic            is_skip;
  logic            is_br;
  logic [PC_W-1:0] exp_br;
  logic [PC_W-1:0] exp_skip;

  assign is_skip  = (issue.op >= OP_SKIP_REG_BIT_CLEAR) && (issue.op <= OP_SKIP_IO_BIT_SET);
  assign is_br    = (issue.op >= OP_BRANCH_FLAG_SET);
  assign exp_br   = pc_in + off_ext + PC_W'(1);
  assign exp_skip = pc_in + (issue.next_two_word ? PC_W'(3) : PC_W'(2));

  a_cmp_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_cmp |=> done && status_we)
    else $error("compare did not finish in one cycle with a flag write");

  a_cmp_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_cmp && (issue.reg_val == issue.imm) |=> status_out[FLAG_Z] && !status_out[FLAG_C])
    else $error("equal compare gave wrong zero or carry");

  a_skip_flags_kept: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_skip |=> !status_we)
    else $error("skip wrote the status register");

  a_skip_pc_step: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_skip && skip_take |=> taken && (pc_next == $past(exp_skip)))
    else $error("taken skip gave wrong program counter");

  a_skip_three_cycles: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_skip && skip_take && issue.next_two_word |=> !done [*2] ##1 done)
    else $error("skip over two-word instruction not three cycles");

  a_branch_taken_two: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_br && br_take |=> !done ##1 (done && pc_load && (pc_next == $past(exp_br, 2))))
    else $error("taken branch wrong target or length");

  a_branch_not_taken: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_br && !br_take |=> done && !taken && (pc_next == $past(pc_in) + PC_W'(1)))
    else $error("branch not taken did not fall through in one cycle");

  a_branch_no_flags: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_br |=> !status_we)
    else $error("branch wrote the status register");

  a_lower_is_carry: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_LOWER) |=> taken == $past(status_in[FLAG_C]))
    else $error("lower branch does not follow carry");

  a_flag_branch_sel: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_FLAG_CLEAR) |=> taken != $past(status_in[issue.bit_sel]))
    else $error("flag-clear branch ignored selected status bit");

  a_cmp_carry_flag: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_cmp |=> status_out[FLAG_C] == ($past(issue.reg_val) < $past(issue.imm)))
    else $error("compare carry does not match unsigned borrow");

  a_cmp_sign_kept: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_cmp |=> status_out[FLAG_S] == $past(status_in[FLAG_S]))
    else $error("compare altered the sign flag");

  a_skip_not_taken: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_skip && !skip_take |=> done && !taken && (pc_next == $past(pc_in) + PC_W'(1)))
    else $error("skip not taken did not fall through in one cycle");

  a_skip_two_cycles: assert property (@(posedge clk) disable iff (!resetn)
    accept && is_skip && skip_take && !issue.next_two_word |=> !done ##1 (done && pc_load))
    else $error("skip over one-word instruction not two cycles");

  a_reg_clear_test: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_SKIP_REG_BIT_CLEAR)
    |=> taken != $past(issue.reg_val[issue.bit_sel]))
    else $error("register bit clear skip ignored the bit");

  a_reg_set_test: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_SKIP_REG_BIT_SET)
    |=> taken == $past(issue.reg_val[issue.bit_sel]))
    else $error("register bit set skip ignored the bit");

  a_io_clear_test: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_SKIP_IO_BIT_CLEAR)
    |=> taken != $past(issue.io_val[issue.bit_sel]))
    else $error("io bit clear skip ignored the bit");

  a_io_set_test: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_SKIP_IO_BIT_SET)
    |=> taken == $past(issue.io_val[issue.bit_sel]))
    else $error("io bit set skip ignored the bit");

  a_flag_set_sel: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_FLAG_SET) |=> taken == $past(status_in[issue.bit_sel]))
    else $error("flag-set branch ignored selected status bit");

  a_equal_on_zero: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_EQUAL) |=> taken == $past(status_in[FLAG_Z]))
    else $error("equal branch does not follow zero");

  a_not_equal_zero: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_NOT_EQUAL) |=> taken != $past(status_in[FLAG_Z]))
    else $error("not-equal branch does not follow zero");

  a_carry_set_br: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_CARRY_SET) |=> taken == $past(status_in[FLAG_C]))
    else $error("carry-set branch does not follow carry");

  a_carry_clear_br: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_CARRY_CLEAR) |=> taken != $past(status_in[FLAG_C]))
    else $error("carry-clear branch does not follow carry");

  a_same_or_higher: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_SAME_OR_HIGHER) |=> taken != $past(status_in[FLAG_C]))
    else $error("same-or-higher branch does not follow carry");

  a_minus_on_neg: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_MINUS) |=> taken == $past(status_in[FLAG_N]))
    else $error("minus branch does not follow negative");

  a_plus_on_neg: assert property (@(posedge clk) disable iff (!resetn)
    accept && (issue.op == OP_BRANCH_PLUS) |=> taken != $past(status_in[FLAG_N]))
    else $error("plus branch does not follow negative");

endmodule : compare_skip_branch_unit

`default_nettype wire

// ==== dv/testbench.sv ====
`default_nettype none

module testbench
  import cond_flow_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Stimulus and design
  // ****************************************
  logic        clk;
  logic        resetn;
  logic        issue_valid;
  instr_s      issue;
  logic [11:0] pc_in;
  logic [7:0]  status_in;
  logic        issue_ready;
  logic        done;
  logic        busy;
  logic [11:0] pc_next;
  logic        pc_load;
  logic [7:0]  status_out;
  logic        status_we;
  logic        taken;
  int          mismatches = 0;
  int          cmp_count = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  compare_skip_branch_unit #(.PC_W(12)) u_dut (
    .clk(clk), .resetn(resetn), .issue_valid(issue_valid), .issue(issue),
    .pc_in(pc_in), .status_in(status_in), .issue_ready(issue_ready), .done(done),
    .busy(busy), .pc_next(pc_next), .pc_load(pc_load), .status_out(status_out),
    .status_we(status_we), .taken(taken)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic idle(input string nm);
    issue_valid = 1'b0;
    tick;
    $display("test %s finished", nm);
  endtask : idle

  function automatic logic [7:0] cmp_st(input logic [7:0] a, b, st);
    logic [7:0] r;
    logic [7:0] o;
    r = a - b;
    o = st;
    o[FLAG_C] = a < b;
    o[FLAG_Z] = (r == 8'h00);
    o[FLAG_N] = r[7];
    o[FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
    o[FLAG_H] = a[3:0] < b[3:0];
    return o;
  endfunction : cmp_st

  function automatic logic [11:0] tgt(input logic [11:0] pc, input logic [6:0] k);
    return pc + {{5{k[6]}}, k} + 12'h001;
  endfunction : tgt

  // Holds the request up while refused; returns in the done cycle for back to back use
  task automatic do_op(input op_e op, input logic [7:0] r, m, io, st, input logic [2:0] s,
                       input logic [6:0] k, input logic tw, input logic [11:0] pc,
                       input int cyc, input logic [11:0] epc, input logic et);
    int n;
    issue_valid = 1'b1;
    issue = '{op, r, m, io, s, k, tw};
    pc_in = pc;
    status_in = st;
    chk("issue_ready", 1, issue_ready);
    tick;
    n = 1;
    while (done !== 1'b1 && n < 6) begin
      chk("busy", 1, busy);
      chk("issue_ready", 0, issue_ready);
      tick;
      n++;
    end
    chk("cycles", cyc, n);
    chk("pc_load", 1, pc_load);
    chk("pc_next", epc, pc_next);
    chk("taken", et, taken);
    chk("status_we", op == OP_COMPARE_IMMEDIATE, status_we);
    if (op == OP_COMPARE_IMMEDIATE) chk("status_out", cmp_st(r, m, st), status_out);
  endtask : do_op

  task automatic chk_rst;
    chk("rst issue_ready", 1, issue_ready);
    chk("rst done", 0, done);
    chk("rst busy", 0, busy);
    chk("rst pc_next", 0, pc_next);
    chk("rst pc_load", 0, pc_load);
    chk("rst taken", 0, taken);
    chk("rst status_out", 0, status_out);
    chk("rst status_we", 0, status_we);
  endtask : chk_rst

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_compare;
    logic [31:0] va;
    logic [31:0] vb;
    va = 32'h05100080;
    vb = 32'h05010101;
    for (int i = 0; i < 4; i++) begin
      do_op(OP_COMPARE_IMMEDIATE, va[31-8*i -: 8], vb[31-8*i -: 8], 8'h5A,
            i[0] ? 8'hFF : 8'h10, 3'h0, 7'h00, 1'b0, 12'h100, 1, 12'h101, 1'b0);
    end
    idle("compare");
  endtask : t_compare

  task automatic t_skip;
    logic       hold;
    logic [2:0] s;
    logic [7:0] v;
    for (int j = 0; j < 4; j++) begin
      for (int c = 0; c < 3; c++) begin
        hold = (c != 2);
        s = 3'(3 * c + j);
        v = (hold == j[0]) ? (8'h01 << s) : ~(8'h01 << s);
        do_op(op_e'(4'h2 + j[3:0]), j < 2 ? v : ~v, 8'h00, j < 2 ? ~v : v, 8'hFF, s,
              7'h00, c == 1, 12'hFFE, hold ? 2 + c : 1, 12'hFFE + (hold ? 2 + c : 1),
              hold);
      end
    end
    idle("skip");
  endtask : t_skip

  task automatic t_flag;
    logic       set;
    logic [2:0] s;
    logic [7:0] st;
    logic [6:0] k;
    for (int i = 0; i < 16; i++) begin
      s = i[2:0];
      set = i[3];
      st = set ? (8'h01 << s) : ~(8'h01 << s);
      k = set ? 7'h40 : 7'h3F;
      do_op(OP_BRANCH_FLAG_SET, 8'h00, 8'h00, 8'h00, st, s, k, 1'b0, 12'h020,
            set ? 2 : 1, set ? tgt(12'h020, k) : 12'h021, set);
      do_op(OP_BRANCH_FLAG_CLEAR, 8'h00, 8'h00, 8'h00, st, s, k, 1'b0, 12'h020,
            set ? 1 : 2, set ? 12'h021 : tgt(12'h020, k), !set);
    end
    idle("flag");
  endtask : t_flag

  task automatic t_named;
    logic [7:0] pv;
    logic [7:0] st;
    logic       tk;
    int         fl;
    pv = 8'b01001101;
    for (int j = 0; j < 8; j++) begin
      fl = (j < 2) ? FLAG_Z : (j < 6) ? FLAG_C : FLAG_N;
      for (int v = 0; v < 2; v++) begin
        st = v[0] ? (8'h01 << fl) : ~(8'h01 << fl);
        tk = (v[0] == pv[j]);
        do_op(op_e'(4'h8 + j[3:0]), 8'h00, 8'h00, 8'h00, st, 3'h0, 7'h05, 1'b0, 12'h7FF,
              tk ? 2 : 1, tk ? 12'h805 : 12'h800,
              tk);
      end
    end
    idle("named");
  endtask : t_named

  task automatic t_reset;
    issue_valid = 1'b1;
    issue = '{OP_SKIP_REG_BIT_SET, 8'hFF, 8'h00, 8'h00, 3'h0, 7'h00, 1'b1};
    pc_in = 12'h123;
    status_in = 8'h00;
    tick;
    issue_valid = 1'b0;
    tick;
    chk("busy", 1, busy);
    resetn = 1'b0;
    #1;
    chk_rst;
    tick;
    resetn = 1'b1;
    tick;
    do_op(OP_NONE, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 12'h123,
          1, 12'h124, 1'b0);
    idle("reset");
  endtask : t_reset

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    final_report;
  end

  initial begin
    resetn = 1'b0;
    issue_valid = 1'b0;
    issue = '0;
    pc_in = '0;
    status_in = '0;
    repeat (5) @(posedge clk);
    #1;
    chk_rst;
    resetn = 1'b1;
    tick;
    t_compare;
    t_skip;
    t_flag;
    t_named;
    t_reset;
    final_report;
  end

endmodule : testbench

`default_nettype wire
